// *** inc/pci_defs.svh ***
// offsets, field positions, register numbers and counts of the interrupt unit
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH

// word bit n (bit 0 = most significant) sits at vector index 15-n
`define PCI_PREP_MASK_BIT   0
`define PCI_PREP_LVL_MSB    4
`define PCI_PREP_LVL_LSB    1
`define PCI_LSR_CC_MSB      15
`define PCI_LSR_CC_LSB      13
`define PCI_LSR_SUPER_BIT   7
`define PCI_LSR_INPROC_BIT  6
`define PCI_LSR_TRACE_BIT   5
`define PCI_LSR_SUMMARY_BIT 4

`define PCI_DDB_BASE        16'h0030
`define PCI_DDB_LAST        16'h022F
`define PCI_VEC_MCHK        16'h0008
`define PCI_VEC_PCHK        16'h000C
`define PCI_VEC_SVC         16'h0010
`define PCI_VEC_PWR         16'h0014
`define PCI_VEC_TRACE       16'h0018
`define PCI_VEC_CONS        16'h001C
`define PCI_VEC_SOFT        16'h0020
`define PCI_SIA_OFS         16'h0002

`define PCI_ID_REG          3'h7
`define PCI_DDB_REG         3'h1
`define PCI_LSB_LAST        4'hA
`define PCI_LSB_GPR_FIRST   4'h3
`define PCI_EXC_COUNT       14
`define PCI_LEVELS          4

`endif

// *** inc/pci_pkg.sv ***
// types shared by the interrupt unit modules
package pci_pkg;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_IO_ID   = 3'b001,
    S_IO_DDB  = 3'b010,
    S_IO_SIA  = 3'b011,
    S_CL_PTR  = 3'b100,
    S_CL_SAVE = 3'b101,
    S_CL_SIA  = 3'b110
  } pci_fsm_type;

  typedef enum logic [2:0] {
    CL_MCHK  = 3'b000,
    CL_PCHK  = 3'b001,
    CL_PWR   = 3'b010,
    CL_SVC   = 3'b011,
    CL_SOFT  = 3'b100,
    CL_TRACE = 3'b101,
    CL_CONS  = 3'b110
  } pci_class_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] id_word;
    logic [2:0]  cond_code;
  } pci_id_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pci_mem_type;

  typedef struct packed {
    logic        we;
    logic [1:0]  level;
    logic [2:0]  idx;
    logic [15:0] data;
  } pci_rf_wr_type;

  typedef struct packed {
    logic        we;
    logic [1:0]  level;
    logic [15:0] data;
  } pci_lvl_wr_type;

  typedef struct packed {
    pci_fsm_type    fsm;
    logic [3:0]     act;
    logic           waiting;
    logic [1:0]     lvl;
    pci_class_type  cls;
    logic           forced;
    logic [15:0]    ptr;
    logic [3:0]     cnt;
    logic [15:0]    sv_iar;
    logic [7:0]     dev;
    logic           ack;
    pci_rf_wr_type  rf;
    pci_lvl_wr_type level_status_reg;
    pci_lvl_wr_type instr_address_reg;
    logic [15:0]    prep;
    logic           prep_stb;
    logic           prep_lost;
  } pci_state_type;

endpackage

// *** src/pci_level_arbiter.sv ***
// picks the highest acceptable i/o request level
`timescale 1ns/1ps
module pci_level_arbiter #(
  parameter int LEVELS = 4
) (
  input  wire logic [LEVELS-1:0] io_req,
  input  wire logic [LEVELS-1:0] io_dev_mask,
  input  wire logic [LEVELS-1:0] level_mask,
  input  wire logic              summary_on,
  input  wire logic              stopped,
  input  wire logic              waiting,
  input  wire logic [1:0]        cur_level,
  output logic                   grant,
  output logic [1:0]             grant_level
);
  import pci_pkg::*;

  logic [LEVELS-1:0] elig;

  genvar g;
  generate
    for (g = 0; g < LEVELS; g++) begin : g_lvl
      // a request on the active level or below waits for a level exit
      assign elig[g] = io_req[g] & io_dev_mask[g] & level_mask[g] & summary_on & ~stopped
                       & (waiting | (2'(g) < cur_level));
    end
  endgenerate

  always_comb begin
    grant       = 1'b0;
    grant_level = 2'h0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (elig[i]) begin
        grant       = 1'b1;
        grant_level = 2'(i);
      end
    end
  end

endmodule

// *** src/pci_class_prio.sv ***
// orders pending exception conditions and maps the winner to its routine
`timescale 1ns/1ps
module pci_class_prio #(
  parameter int N = 14
) (
  input  wire logic [N-1:0]       exc_cond,
  input  wire logic               summary_on,
  input  wire logic               console_hold,
  output logic                    cls_valid,
  output pci_pkg::pci_class_type  cls
);
  import pci_pkg::*;

  logic [N-1:0] elig;
  logic [3:0]   prio;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_exc
      if (g == 7) begin : g_pwr
        assign elig[g] = exc_cond[g] & summary_on & ~console_hold;
      end else if (g == 13) begin : g_cons
        assign elig[g] = exc_cond[g] & summary_on;
      end else if (g == 0 || g == 1 || g == 2 || g == 3 || g == 5 || g == 6) begin : g_chk
        assign elig[g] = exc_cond[g] & ~console_hold;
      end else if (g == 4 || g == 10) begin : g_na
        assign elig[g] = 1'b0;
      end else begin : g_any
        assign elig[g] = exc_cond[g];
      end
    end
  endgenerate

  always_comb begin
    cls_valid = |elig;
    prio      = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (elig[i]) begin
        prio = 4'(i);
      end
    end
    case (prio)
      4'h0, 4'h6:               cls = CL_MCHK;
      4'h1, 4'h2, 4'h3, 4'h5:   cls = CL_PCHK;
      4'h7:                     cls = CL_PWR;
      4'h8:                     cls = CL_SVC;
      4'h9, 4'hB:               cls = CL_SOFT;
      4'hC:                     cls = CL_TRACE;
      default:                  cls = CL_CONS;
    endcase
  end

endmodule

// *** src/pci_intr_unit.sv ***
// priority level and class interrupt acceptance and dispatch unit
// Functional notes
// - prepare word: bits 0-10 zero, level code in 11-14, device mask in 15.
// - only levels 0-3 exist; level code with bit 11 or 12 set is lost.
// - accept i/o when all masks on, highest above current, not stopped.
// - condition code goes to status bits 0-2 of the new level.
// - switch to new level; id word written to its register 7.
// - accepting a priority interrupt sets supervisor bit 8.
// - device block pointer to register 1, then entry address to instruction reg.
// - device pointer word sits at 0x0030 plus twice the device address.
// - class interrupt keeps the active level, or level zero when waiting.
// - class interrupt in wait forces level zero; saved bit 9 reads zero.
// - summary mask blocks only power/thermal and console class interrupts.
// - check-restart or stop-on-error blocks machine, power and program checks.
// - simultaneous exceptions serviced lowest priority number first.
// - floating point and stack go to soft trap; trace 12, console 13.
// - class entry sets supervisor, clears trace and summary mask bits.
// - class entry saves state at its block pointer, then loads entry address.
// - saved block: address, zero, status, registers 0-7 (R7 at +0x14).
// - saved address is next or causing instruction by class type.
// - machine check with sequence indicator on saves the executing address.
// - current level request waits for level exit; no level left means wait.
`timescale 1ns/1ps
`include "pci_defs.svh"
module pci_intr_unit #(
  parameter int LEVELS = `PCI_LEVELS,
  parameter int NEXC   = `PCI_EXC_COUNT
) (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic                    instr_boundary,
  input  wire logic                    abort_error,
  input  wire logic                    level_exit_op,
  input  wire logic                    stopped,
  input  wire logic [LEVELS-1:0]       level_mask,
  input  wire logic [LEVELS-1:0]       io_req,
  input  wire logic [LEVELS-1:0]       io_dev_mask,
  input  wire pci_pkg::pci_id_type     id_in,
  input  wire logic [NEXC-1:0]         exc_cond,
  input  wire logic                    seq_ind,
  input  wire logic                    check_restart,
  input  wire logic                    stop_on_error,
  input  wire logic [15:0]             next_iar,
  input  wire logic [15:0]             cause_iar,
  input  wire logic [15:0]             exec_iar,
  input  wire logic [15:0]             lsr_rdata,
  input  wire logic [15:0]             gpr_rdata,
  input  wire logic                    mem_rdy,
  input  wire logic [15:0]             mem_rdata,
  input  wire logic                    prep_valid,
  input  wire logic [3:0]              prep_level,
  input  wire logic                    prep_dev_mask,
  output logic                         busy,
  output logic [1:0]                   active_level,
  output logic                         wait_state,
  output logic                         intr_ack,
  output logic [1:0]                   ack_level,
  output logic [1:0]                   rd_level,
  output logic [2:0]                   gpr_rd_idx,
  output pci_pkg::pci_mem_type         mem,
  output pci_pkg::pci_rf_wr_type       rf_wr,
  output pci_pkg::pci_lvl_wr_type      lsr_wr,
  output pci_pkg::pci_lvl_wr_type      iar_wr,
  output logic [15:0]                  prepare_word,
  output logic                         prepare_strobe,
  output logic                         prepare_lost
);
  import pci_pkg::*;

  pci_state_type q;
  pci_state_type d;
  logic          grant;
  logic [1:0]    grant_level;
  logic          cls_valid;
  pci_class_type cls;
  logic [1:0]    cur;
  logic          summary_on;
  logic [15:0]   vec;
  logic [3:0]    act_left;
  logic [3:0]    gidx;

  // active level is the most urgent level still in service
  always_comb begin
    cur = 2'h0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (q.act[i]) begin
        cur = 2'(i);
      end
    end
  end

  assign summary_on = lsr_rdata[`PCI_LSR_SUMMARY_BIT];

  pci_level_arbiter #(
    .LEVELS      (LEVELS)
  ) u_arb (
    .io_req      (io_req),
    .io_dev_mask (io_dev_mask),
    .level_mask  (level_mask),
    .summary_on  (summary_on),
    .stopped     (stopped),
    .waiting     (q.waiting),
    .cur_level   (cur),
    .grant       (grant),
    .grant_level (grant_level)
  );

  pci_class_prio #(
    .N            (NEXC)
  ) u_cls (
    .exc_cond     (exc_cond),
    .summary_on   (summary_on),
    .console_hold (check_restart | stop_on_error),
    .cls_valid    (cls_valid),
    .cls          (cls)
  );

  always_comb begin
    case (q.cls)
      CL_MCHK:  vec = `PCI_VEC_MCHK;
      CL_PCHK:  vec = `PCI_VEC_PCHK;
      CL_PWR:   vec = `PCI_VEC_PWR;
      CL_SVC:   vec = `PCI_VEC_SVC;
      CL_SOFT:  vec = `PCI_VEC_SOFT;
      CL_TRACE: vec = `PCI_VEC_TRACE;
      default:  vec = `PCI_VEC_CONS;
    endcase
  end

  // status and register reads follow the level being serviced
  assign rd_level   = (q.fsm == S_IDLE) ? (q.waiting ? 2'h0 : cur) : q.lvl;
  assign gidx       = q.cnt - `PCI_LSB_GPR_FIRST;
  assign gpr_rd_idx = gidx[2:0];

  // memory port is decoded straight from the state so a ready ends the word at once
  always_comb begin
    mem = '0;
    case (q.fsm)
      S_IO_DDB: begin
        mem.req  = 1'b1;
        mem.addr = `PCI_DDB_BASE + {7'h00, q.dev, 1'b0};
      end
      S_IO_SIA: begin
        mem.req  = 1'b1;
        mem.addr = q.ptr;
      end
      S_CL_PTR: begin
        mem.req  = 1'b1;
        mem.addr = vec;
      end
      S_CL_SAVE: begin
        mem.req  = 1'b1;
        mem.we   = 1'b1;
        mem.addr = q.ptr + {11'h000, q.cnt, 1'b0};
        if (q.cnt == 4'h0) begin
          mem.wdata = q.sv_iar;
        end else if (q.cnt == 4'h1) begin
          mem.wdata = 16'h0000;
        end else if (q.cnt == 4'h2) begin
          mem.wdata = lsr_rdata;
          if (q.forced) begin
            mem.wdata[`PCI_LSR_INPROC_BIT] = 1'b0;
          end
        end else begin
          mem.wdata = gpr_rdata;
        end
      end
      S_CL_SIA: begin
        mem.req  = 1'b1;
        mem.addr = vec + `PCI_SIA_OFS;
      end
      default: begin
        mem = '0;
      end
    endcase
  end

  always_comb begin
    d            = q;
    d.rf.we      = 1'b0;
    d.level_status_reg.we     = 1'b0;
    d.instr_address_reg.we     = 1'b0;
    d.prep_stb   = 1'b0;
    act_left     = q.act & ~(4'h1 << cur);
    if (prep_valid) begin
      d.prep      = {11'h000, prep_level, prep_dev_mask};
      d.prep_stb  = 1'b1;
      // upper level bits set: the device would ask on a level that is never served
      d.prep_lost = |prep_level[3:2];
    end
    case (q.fsm)
      S_IDLE: begin
        if (level_exit_op && !q.waiting) begin
          d.act = act_left;
          if (act_left == 4'h0) begin
            d.waiting = 1'b1;
          end
        end else if ((instr_boundary || abort_error || q.waiting) && cls_valid) begin
          d.cls    = cls;
          d.lvl    = q.waiting ? 2'h0 : cur;
          d.forced = q.waiting;
          if (q.waiting) begin
            d.act     = q.act | 4'h1;
            d.waiting = 1'b0;
          end
          case (cls)
            CL_SVC, CL_TRACE, CL_CONS, CL_PWR: d.sv_iar = next_iar;
            CL_MCHK: d.sv_iar = seq_ind ? exec_iar : cause_iar;
            default: d.sv_iar = cause_iar;
          endcase
          d.fsm = S_CL_PTR;
        end else if ((instr_boundary || q.waiting) && grant) begin
          d.lvl = grant_level;
          d.ack = 1'b1;
          d.fsm = S_IO_ID;
        end
      end
      S_IO_ID: begin
        if (id_in.valid) begin
          d.ack     = 1'b0;
          d.act     = q.act | (4'h1 << q.lvl);
          d.waiting = 1'b0;
          d.dev     = id_in.id_word[7:0];
          d.rf.we   = 1'b1;
          d.rf.level = q.lvl;
          d.rf.idx  = `PCI_ID_REG;
          d.rf.data = id_in.id_word;
          d.level_status_reg.we  = 1'b1;
          d.level_status_reg.level = q.lvl;
          d.level_status_reg.data = lsr_rdata;
          d.level_status_reg.data[`PCI_LSR_CC_MSB:`PCI_LSR_CC_LSB] = id_in.cond_code;
          d.level_status_reg.data[`PCI_LSR_SUPER_BIT] = 1'b1;
          d.level_status_reg.data[`PCI_LSR_TRACE_BIT] = 1'b0;
          d.fsm     = S_IO_DDB;
        end
      end
      S_IO_DDB: begin
        if (mem_rdy) begin
          d.ptr      = mem_rdata;
          d.rf.we    = 1'b1;
          d.rf.level = q.lvl;
          d.rf.idx   = `PCI_DDB_REG;
          d.rf.data  = mem_rdata;
          d.fsm      = S_IO_SIA;
        end
      end
      S_IO_SIA: begin
        if (mem_rdy) begin
          d.instr_address_reg.we    = 1'b1;
          d.instr_address_reg.level = q.lvl;
          d.instr_address_reg.data  = mem_rdata;
          d.fsm       = S_IDLE;
        end
      end
      S_CL_PTR: begin
        if (mem_rdy) begin
          d.ptr = mem_rdata;
          d.cnt = 4'h0;
          d.fsm = S_CL_SAVE;
        end
      end
      S_CL_SAVE: begin
        if (mem_rdy) begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == `PCI_LSB_LAST) begin
            // status changes only once the saved copy holds the old value
            d.level_status_reg.we    = 1'b1;
            d.level_status_reg.level = q.lvl;
            d.level_status_reg.data  = lsr_rdata;
            d.level_status_reg.data[`PCI_LSR_SUPER_BIT]   = 1'b1;
            d.level_status_reg.data[`PCI_LSR_TRACE_BIT]   = 1'b0;
            d.level_status_reg.data[`PCI_LSR_SUMMARY_BIT] = 1'b0;
            d.fsm = S_CL_SIA;
          end
        end
      end
      S_CL_SIA: begin
        if (mem_rdy) begin
          d.instr_address_reg.we    = 1'b1;
          d.instr_address_reg.level = q.lvl;
          d.instr_address_reg.data  = mem_rdata;
          d.fsm       = S_IDLE;
        end
      end
      default: begin
        d.fsm = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q         <= '0;
      q.fsm     <= S_IDLE;
      q.cls     <= CL_MCHK;
      q.waiting <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign busy           = (q.fsm != S_IDLE);
  assign active_level   = cur;
  assign wait_state     = q.waiting;
  assign intr_ack       = q.ack;
  assign ack_level      = q.lvl;
  assign rf_wr          = q.rf;
  assign lsr_wr         = q.level_status_reg;
  assign iar_wr         = q.instr_address_reg;
  assign prepare_word   = q.prep;
  assign prepare_strobe = q.prep_stb;
  assign prepare_lost   = q.prep_lost;

endmodule

// *** bench/pci_intr_unit_checker.sv ***
// port-level assertions for the interrupt unit
`timescale 1ns/1ps
module pci_intr_unit_checker #(
  parameter int LEVELS = 4
) (
  input wire logic                    clock,
  input wire logic                    reset,
  input wire logic                    stopped,
  input wire logic [LEVELS-1:0]       level_mask,
  input wire logic [LEVELS-1:0]       io_req,
  input wire logic [LEVELS-1:0]       io_dev_mask,
  input wire pci_pkg::pci_id_type     id_in,
  input wire logic [15:0]             lsr_rdata,
  input wire logic                    mem_rdy,
  input wire logic                    prep_valid,
  input wire logic [3:0]              prep_level,
  input wire logic                    prep_dev_mask,
  input wire logic [1:0]              active_level,
  input wire logic                    wait_state,
  input wire logic                    intr_ack,
  input wire logic [1:0]              ack_level,
  input wire pci_pkg::pci_mem_type    mem,
  input wire pci_pkg::pci_rf_wr_type  rf_wr,
  input wire pci_pkg::pci_lvl_wr_type lsr_wr,
  input wire logic [15:0]             prepare_word,
  input wire logic                    prepare_strobe,
  input wire logic                    prepare_lost
);
  import pci_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // levels that were acceptable one cycle ago, so a fresh ack can be traced to its cause
  logic [LEVELS-1:0] elig_q;
  always_ff @(posedge clock) begin
    elig_q <= level_mask & io_req & io_dev_mask & {LEVELS{!stopped && lsr_rdata[4]}};
  end
  prep_fmt_a: assert property ($past(prep_valid) |-> prepare_strobe &&
    prepare_word == {11'h000, $past(prep_level), $past(prep_dev_mask)}) else $error("bad prepare");
  prep_lost_a: assert property ($past(prep_valid) |->
    prepare_lost == ($past(prep_level[3]) | $past(prep_level[2]))) else $error("bad lost flag");
  io_accept_a: assert property ($rose(intr_ack) |-> elig_q[ack_level] &&
    (elig_q & ((LEVELS'(1) << ack_level) - LEVELS'(1))) == '0) else $error("bad accept");
  io_above_a: assert property ($rose(intr_ack) |->
    $past(wait_state) || ack_level < $past(active_level)) else $error("ack not above level");
  id_r7_a: assert property (intr_ack && id_in.valid |=> rf_wr.we && rf_wr.idx == 3'h7 &&
    rf_wr.data == $past(id_in.id_word) && rf_wr.level == $past(ack_level)) else $error("bad r7");
  io_lsr_a: assert property (intr_ack && id_in.valid |=> lsr_wr.we && lsr_wr.data[7] &&
    lsr_wr.data[15:13] == $past(id_in.cond_code)) else $error("bad io status");
  ddb_addr_a: assert property (intr_ack && id_in.valid |=> mem.req && !mem.we &&
    mem.addr == 16'h0030 + {7'h00, $past(id_in.id_word[7:0]), 1'b0}) else $error("bad ddb addr");
  id_first_a: assert property (rf_wr.we && rf_wr.idx == 3'h7 |->
    $past(intr_ack) && $past(id_in.valid)) else $error("r7 before id");
  mem_hold_a: assert property (mem.req && !mem_rdy |=> mem.req &&
    $stable(mem.addr) && $stable(mem.we)) else $error("mem request dropped");
  cls_lsr_a: assert property (lsr_wr.we && !$past(id_in.valid) |->
    lsr_wr.data[7] && lsr_wr.data[5:4] == 2'b00) else $error("bad class status");
  cls_level_a: assert property (lsr_wr.we && !$past(id_in.valid) |->
    lsr_wr.level == active_level) else $error("class changed level");
  cover property ($rose(intr_ack));
  cover property (lsr_wr.we && !lsr_wr.data[4]);
  cover property (prepare_strobe && prepare_lost);
endmodule

bind pci_intr_unit pci_intr_unit_checker #(.LEVELS(LEVELS)) chk (.clock, .reset, .stopped,
  .level_mask, .io_req, .io_dev_mask, .id_in, .lsr_rdata, .mem_rdy, .prep_valid, .prep_level,
  .prep_dev_mask, .active_level, .wait_state, .intr_ack, .ack_level, .mem, .rf_wr, .lsr_wr,
  .prepare_word, .prepare_strobe, .prepare_lost);

// *** bench/pci_io_dev_model.sv ***
// behavioural attached device: prepare latch, request line, id answer
`timescale 1ns/1ps
module pci_io_dev_model #(
  parameter logic [7:0] DEV  = 8'h5C,
  parameter logic [7:0] INFO = 8'hA3
) (
  input wire logic                clock,
  input wire logic                reset,
  input wire logic [15:0]         prepare_word,
  input wire logic                prepare_strobe,
  input wire logic                intr_ack,
  input wire logic [1:0]          ack_level,
  input wire logic                raise,
  input wire logic [3:0]          dly,
  input wire logic [2:0]          cc,
  output logic [3:0]              io_req,
  output logic [3:0]              io_dev_mask,
  output pci_pkg::pci_id_type     id_in
);
  import pci_pkg::*;
  logic [3:0] lvl_q;
  logic [3:0] cnt_q;
  logic       mask_q;
  logic       pend_q;
  logic       ans_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      lvl_q <= 4'h0;
      mask_q <= 1'b0;
      pend_q <= 1'b0;
      ans_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      ans_q <= 1'b0;
      if (prepare_strobe) begin
        lvl_q <= prepare_word[4:1];
        mask_q <= prepare_word[0];
      end
      if (raise) begin
        pend_q <= 1'b1;
      end
      // dly stretches the answer so slow devices are exercised too
      if (intr_ack && !ans_q && pend_q && ack_level == lvl_q[1:0]) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == dly) begin
          ans_q <= 1'b1;
          pend_q <= 1'b0;
          cnt_q <= 4'h0;
        end
      end
    end
  end
  // a masked device or one on a level the processor lacks stays silent
  assign io_req = (pend_q && mask_q && lvl_q < 4'h4) ? 4'h1 << lvl_q[1:0] : 4'h0;
  assign io_dev_mask = {4{mask_q}};
  assign id_in = ans_q ? {1'b1, INFO, DEV, cc} : {1'b0, ~INFO, ~DEV, ~cc};
endmodule

// *** bench/pci_intr_unit_tb_top.sv ***
// self-checking bench for the interrupt unit
`timescale 1ns/1ps
module pci_intr_unit_tb_top;
  import pci_pkg::*;
  localparam logic [7:0]  DEV = 8'h5C;
  localparam logic [7:0]  INFO = 8'hA3;
  localparam logic [15:0] NIA = 16'h1236;
  localparam logic [15:0] CIA = 16'h1234;
  localparam logic [15:0] XIA = 16'h1230;
  localparam logic [13:0] NXT = 14'h3180;
  localparam logic [7:0]  VEC [14] = '{8'h08, 8'h0C, 8'h0C, 8'h0C, 8'h00, 8'h0C, 8'h08,
                                      8'h14, 8'h10, 8'h20, 8'h00, 8'h20, 8'h18, 8'h1C};
  logic           clock = 1'b0, reset = 1'b1, ib = 1'b1, abort_error = 1'b0, lexit = 1'b0;
  logic           stopped = 1'b0, seq_ind = 1'b0, check_restart = 1'b0, stop_on_error = 1'b0;
  logic           prep_valid = 1'b0, prep_dev_mask = 1'b0, raise = 1'b0, mem_rdy = 1'b0;
  logic [3:0]     level_mask = 4'hF, prep_level = 4'h0, dly = 4'h0;
  logic [1:0]     stall = 2'h0, stall_c = 2'h0;
  logic [2:0]     cc = 3'h0;
  logic [13:0]    exc_cond = 14'h0000;
  logic [15:0]    lsr_v = 16'h0A70, mem_rdata = 16'h0000, gpr_rdata;
  logic [15:0]    wa [16], wd [16], rf_c [8];
  int             nw = 0, n_iar = 0, err_count = 0, comparisons = 0;
  pci_lvl_wr_type lsr_c, iar_c, lsr_wr, iar_wr;
  logic [3:0]     io_req, io_dev_mask;
  pci_id_type     id_in;
  logic           busy, wait_state, intr_ack, prepare_strobe, prepare_lost;
  logic [1:0]     active_level, ack_level, rd_level;
  logic [2:0]     gpr_rd_idx;
  logic [15:0]    prepare_word;
  pci_mem_type    mem;
  pci_rf_wr_type  rf_wr;

  pci_intr_unit uut (.clock, .reset, .instr_boundary(ib), .abort_error, .level_exit_op(lexit),
    .stopped, .level_mask, .io_req, .io_dev_mask, .id_in, .exc_cond, .seq_ind, .check_restart,
    .stop_on_error, .next_iar(NIA), .cause_iar(CIA), .exec_iar(XIA), .lsr_rdata(lsr_v),
    .gpr_rdata, .mem_rdy, .mem_rdata, .prep_valid, .prep_level, .prep_dev_mask, .busy,
    .active_level, .wait_state, .intr_ack, .ack_level, .rd_level, .gpr_rd_idx, .mem, .rf_wr,
    .lsr_wr, .iar_wr, .prepare_word, .prepare_strobe, .prepare_lost);
  pci_io_dev_model #(.DEV(DEV), .INFO(INFO)) dev (.clock, .reset, .prepare_word,
    .prepare_strobe, .intr_ack, .ack_level, .raise, .dly, .cc, .io_req, .io_dev_mask, .id_in);

  always #2.5 clock = ~clock;
  assign gpr_rdata = {11'h2A0, rd_level, gpr_rd_idx};
  function automatic logic [15:0] f(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h3C5A;
  endfunction
  // memory answers after a settable stall; idle data keeps toggling
  always @(negedge clock) begin
    if (mem.req && stall_c >= stall) begin
      mem_rdy <= 1'b1;
      mem_rdata <= f(mem.addr);
      stall_c <= 2'h0;
    end else begin
      mem_rdy <= 1'b0;
      mem_rdata <= ~mem_rdata;
      stall_c <= mem.req ? stall_c + 2'h1 : 2'h0;
    end
  end
  always @(posedge clock) begin
    if (mem.req && mem.we && mem_rdy) begin
      wa[nw[3:0]] = mem.addr;
      wd[nw[3:0]] = mem.wdata;
      nw++;
    end
    if (rf_wr.we) rf_c[rf_wr.idx] = rf_wr.data;
    if (lsr_wr.we) lsr_c = lsr_wr;
    if (iar_wr.we) begin
      iar_c = iar_wr;
      n_iar++;
    end
  end

  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_done(input int n0);
    int k;
    k = 0;
    rf_c[1] = 'x;
    rf_c[7] = 'x;
    lsr_c = 'x;
    iar_c = 'x;
    while ((n_iar == n0 || busy) && k < 400) begin
      @(negedge clock);
      k++;
    end
    if (k == 400) begin
      err_count++;
      $display("[FAIL] %0t ns: no completion", $time);
      end_sim();
    end
  endtask
  task automatic prep(input logic [3:0] l, input logic m);
    prep_valid = 1'b1;
    prep_level = l;
    prep_dev_mask = m;
    @(negedge clock);
    prep_valid = 1'b0;
    @(negedge clock);
  endtask
  task automatic exit_lvl();
    lexit = 1'b1;
    @(negedge clock);
    lexit = 1'b0;
    @(negedge clock);
  endtask
  // blk: 0 none, 1 stop, 2 level mask, 3 summary, 4 device mask, 5 lost level, 6 same level
  task automatic t_io(input logic [1:0] l, input int blk);
    int n0;
    n0 = n_iar;
    dly = 4'(blk);
    stall = 2'(blk);
    cc = {1'b1, l};
    prep({blk == 5, 1'b0, l}, blk != 4);
    stopped = blk == 1;
    level_mask[l] = blk != 2;
    lsr_v[4] = blk != 3;
    raise = 1'b1;
    @(negedge clock);
    raise = 1'b0;
    if (blk != 0) begin
      repeat (12) @(negedge clock);
      check(16'(intr_ack), 16'h0000);
      stopped = 1'b0;
      level_mask = 4'hF;
      lsr_v[4] = 1'b1;
      if (blk == 6) exit_lvl();
      else prep({2'h0, l}, 1'b1);
    end
    wait_done(n0);
    check(rf_c[7], {INFO, DEV});
    check(rf_c[1], f(16'h0030 + {7'h00, DEV, 1'b0}));
    check(iar_c.data, f(f(16'h0030 + {7'h00, DEV, 1'b0})));
    check({13'h0000, lsr_c.data[15:13]}, {13'h0000, cc});
    check({14'h0000, active_level}, {14'h0000, l});
  endtask
  task automatic t_cls(input logic [13:0] c, input int b, input logic [15:0] ia, input logic w);
    int n0;
    logic [15:0] p;
    logic [1:0] lv;
    n0 = n_iar;
    lv = active_level;
    nw = 0;
    p = f({8'h00, VEC[b]});
    exc_cond = c;
    @(negedge clock);
    exc_cond = 14'h0000;
    wait_done(n0);
    check(wa[0], p);
    check(wd[0], ia);
    check(wd[1], 16'h0000);
    check(wd[2], w ? lsr_v & 16'hFFBF : lsr_v);
    check(wa[10], p + 16'h0014);
    check(wd[10], {11'h2A0, lv, 3'h7});
    check(16'(nw), 16'h000B);
    check(iar_c.data, f({8'h00, VEC[b]} + 16'h0002));
    check({14'h0000, lsr_c.level}, {14'h0000, lv});
    check(16'(lsr_c.data[4]), 16'h0000);
  endtask

  initial begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    check(16'(wait_state), 16'h0001);
    t_cls(14'h0100, 8, NIA, 1'b1);
    exit_lvl();
    check(16'(wait_state), 16'h0001);
    for (int i = 0; i < 32; i++) begin
      prep(i[3:0], i[4]);
      check(prepare_word, {11'h000, i[3:0], i[4]});
      check(16'(prepare_lost), 16'(i[3] | i[2]));
    end
    t_io(2'h3, 0);
    t_io(2'h2, 1);
    t_io(2'h1, 2);
    t_io(2'h0, 3);
    repeat (4) exit_lvl();
    check(16'(wait_state), 16'h0001);
    t_io(2'h3, 4);
    t_io(2'h2, 5);
    t_io(2'h2, 6);
    for (int b = 0; b < 14; b++) begin
      if (VEC[b] != 8'h00) t_cls(14'h2000 | (14'h0001 << b), b, NXT[b] ? NIA : CIA, 1'b0);
    end
    lsr_v[4] = 1'b0;
    t_cls(14'h3080, 12, NIA, 1'b0);
    lsr_v[4] = 1'b1;
    check_restart = 1'b1;
    t_cls(14'h0283, 9, CIA, 1'b0);
    check_restart = 1'b0;
    stop_on_error = 1'b1;
    t_cls(14'h106C, 12, NIA, 1'b0);
    stop_on_error = 1'b0;
    seq_ind = 1'b1;
    ib = 1'b0;
    exc_cond = 14'h0001;
    repeat (10) @(negedge clock);
    check(16'(busy), 16'h0000);
    abort_error = 1'b1;
    t_cls(14'h0001, 0, XIA, 1'b0);
    end_sim();
  end
endmodule
